// File: hw/fsbl_pkg.sv
// Package: constants and state type of the fast shut-off logic function element
// Functional notes
// - Plain variant monitors one to eight safety inputs from one module.
// - Bypass variant monitors one to seven inputs; last position is bypass.
// - Switched output is selected only among this module's own outputs.
// - Each input may be assigned to zone one, zone two or both.
// - A zone is good when it has at least one input assigned and all inputs assigned to it are high.
// - The two zone results are ORed; one good zone permits the output.
// - Output turns on only if a zone was good before the logic enable.
// - In bypass variant a high bypass suppresses the fast shut-off.
// - State output is indication only; the switched output comes from configuration.
// - Failing zone result switches the selected output off at once.
// - Bypass acts after three cycles high; release acts at once.
package fsbl_pkg;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int unsigned NUM_IN = 8;
   localparam int unsigned NUM_OUT = 4;
   localparam logic [3:0] MAX_IN_PLAIN = 4'h8;
   localparam logic [3:0] MAX_IN_BYPASS = 4'h7;
   localparam int unsigned BYPASS_POS = 7;
   localparam logic [1:0] BYPASS_CYCLES = 2'h3;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] ZONE_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   localparam int unsigned CTRL_VARIANT_BIT = 0;
   localparam int unsigned CTRL_COUNT_LSB = 8;
   localparam int unsigned CTRL_SEL_LSB = 16;
   localparam int unsigned ST_ZONE1_BIT = 8;
   localparam int unsigned ST_ZONE2_BIT = 9;
   localparam int unsigned ST_STATE_BIT = 10;
   localparam int unsigned ST_BYPASS_BIT = 11;
   localparam int unsigned ST_PHYS_LSB = 12;
   localparam logic [3:0] COUNT_RESET = 4'h8;
   localparam logic [15:0] ZONE_RESET = 16'h5555;
   localparam logic [1:0] SEL_RESET = 2'h0;

   typedef struct packed {
      logic [31:0] prdata;
      logic variant;
      logic [3:0] count;
      logic [1:0] sel;
      logic [15:0] zone;
      logic zone_ok;
      logic logic_en;
      logic on;
      logic [1:0] byp_cnt;
      logic byp_ok;
      logic state;
      logic [NUM_OUT-1:0] phys;
   } fsbl_state_t;
endpackage

// File: hw/fsbl_zone_if.sv
// Interface: configuration and results between controller and zone evaluator
`timescale 1ns/1ps
interface fsbl_zone_if;
   logic [7:0] inputs;
   logic [3:0] count;
   logic variant;
   logic [15:0] zone;
   logic zone1_ok;
   logic zone2_ok;
   modport ctrl (output inputs, output count, output variant, output zone,
      input zone1_ok, input zone2_ok);
   modport eval (input inputs, input count, input variant, input zone,
      output zone1_ok, output zone2_ok);
endinterface

// File: hw/fsbl_zone_eval.sv
// Zone evaluator: AND inside each zone over the monitored inputs
`timescale 1ns/1ps
module fsbl_zone_eval (
   fsbl_zone_if.eval zif
);
   import fsbl_pkg::*;

   // Zone membership of one input position; unused positions belong nowhere
   function automatic logic member(input logic [15:0] zone, input logic [3:0] count,
         input logic variant, input int unsigned idx, input int unsigned z);
      logic [3:0] lim;
      lim = variant ? ((count > MAX_IN_BYPASS) ? MAX_IN_BYPASS : count) : count;
      member = (4'(idx) < lim) && zone[2*idx+z];
   endfunction

   always_comb begin
      logic any1;
      logic any2;
      logic all1;
      logic all2;
      any1 = 1'b0;
      any2 = 1'b0;
      all1 = 1'b1;
      all2 = 1'b1;
      for (int unsigned i = 0; i < NUM_IN; i++) begin
         if (member(zif.zone, zif.count, zif.variant, i, 0)) begin
            any1 = 1'b1;
            all1 = all1 & zif.inputs[i];
         end
         if (member(zif.zone, zif.count, zif.variant, i, 1)) begin
            any2 = 1'b1;
            all2 = all2 & zif.inputs[i];
         end
      end
      // An empty zone never counts as good, else it would hold the output on
      zif.zone1_ok = any1 & all1;
      zif.zone2_ok = any2 & all2;
   end
endmodule

// File: hw/fsbl_top.sv
// Fast shut-off logic function element with APB register access
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fsbl_top (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [fsbl_pkg::NUM_IN-1:0] safety_in,
   input wire logic [fsbl_pkg::NUM_OUT-1:0] logic_out,
   output logic [fsbl_pkg::NUM_OUT-1:0] phys_out,
   output logic fso_state
);
   import fsbl_pkg::*;

   fsbl_state_t s_q;
   fsbl_state_t s_d;
   fsbl_zone_if zif ();

   fsbl_zone_eval u_eval (
      .zif(zif)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == CTRL_ADDR) || (a == ZONE_ADDR) || (a == STATUS_ADDR);
   endfunction

   function automatic logic [3:0] clamp_count(input logic [3:0] c, input logic variant);
      logic [3:0] lim;
      lim = variant ? MAX_IN_BYPASS : MAX_IN_PLAIN;
      if (c == 4'h0) begin
         clamp_count = 4'h1;
      end else if (c > lim) begin
         clamp_count = lim;
      end else begin
         clamp_count = c;
      end
   endfunction

   assign zif.inputs = safety_in;
   assign zif.count = s_q.count;
   assign zif.variant = s_q.variant;
   assign zif.zone = s_q.zone;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic zone_now;
      logic le;
      logic byp_raw;
      logic [3:0] cnt_w;
      cnt_w = 4'h0;
      s_d = s_q;
      zone_now = zif.zone1_ok | zif.zone2_ok;
      le = logic_out[s_q.sel];
      byp_raw = s_q.variant & safety_in[BYPASS_POS];

      // Register writes take effect in the access phase
      if (psel && penable && pwrite) begin
         if (paddr == CTRL_ADDR) begin
            s_d.variant = pwdata[CTRL_VARIANT_BIT];
            cnt_w = pwdata[CTRL_COUNT_LSB +: 4];
            s_d.count = clamp_count(cnt_w, pwdata[CTRL_VARIANT_BIT]);
            s_d.sel = pwdata[CTRL_SEL_LSB +: 2];
         end else if (paddr == ZONE_ADDR) begin
            s_d.zone = pwdata[15:0];
         end
      end

      // Read data captured in the setup phase so it is stable for the access phase
      if (psel && !penable && !pwrite) begin
         s_d.prdata = 32'h0;
         if (paddr == CTRL_ADDR) begin
            s_d.prdata[CTRL_VARIANT_BIT] = s_q.variant;
            s_d.prdata[CTRL_COUNT_LSB +: 4] = s_q.count;
            s_d.prdata[CTRL_SEL_LSB +: 2] = s_q.sel;
         end else if (paddr == ZONE_ADDR) begin
            s_d.prdata[15:0] = s_q.zone;
         end else if (paddr == STATUS_ADDR) begin
            s_d.prdata[7:0] = safety_in;
            s_d.prdata[ST_ZONE1_BIT] = zif.zone1_ok;
            s_d.prdata[ST_ZONE2_BIT] = zif.zone2_ok;
            s_d.prdata[ST_STATE_BIT] = s_q.state;
            s_d.prdata[ST_BYPASS_BIT] = s_q.byp_ok;
            s_d.prdata[ST_PHYS_LSB +: NUM_OUT] = s_q.phys;
         end
      end

      // Bypass qualifies only after a run of high cycles; a drop clears it at once
      if (byp_raw) begin
         if (s_q.byp_cnt < BYPASS_CYCLES - 2'h1) begin
            s_d.byp_cnt = s_q.byp_cnt + 2'h1;
         end
         s_d.byp_ok = (s_q.byp_cnt >= BYPASS_CYCLES - 2'h1);
      end else begin
         s_d.byp_cnt = 2'h0;
         s_d.byp_ok = 1'b0;
      end

      // Arm only on an enable that arrives after a zone was already good
      s_d.zone_ok = zone_now;
      s_d.logic_en = le;
      s_d.on = zone_now & le & (s_q.on | (s_q.zone_ok & !s_q.logic_en));
      s_d.state = s_d.on | s_d.byp_ok;

      // Only the selected output bypasses the normal logic path
      s_d.phys = logic_out;
      s_d.phys[s_q.sel] = s_d.state;
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.count <= COUNT_RESET;
         s_q.zone <= ZONE_RESET;
         s_q.sel <= SEL_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & (!mapped(paddr) | (pwrite & (paddr == STATUS_ADDR)));
   assign phys_out = s_q.phys;
   assign fso_state = s_q.state;
endmodule

// File: verification/fsbl_top_asserts.sv
// Checker: port-level properties of the fast shut-off element
`timescale 1ns/1ps
module fsbl_top_asserts (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [7:0] safety_in,
   input wire logic [3:0] logic_out,
   input wire logic [3:0] phys_out,
   input wire logic fso_state
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   a_zero_wait: assert property (psel && penable |-> pready) else $error("ready late");
   a_err_in_access: assert property (pslverr |-> psel && penable) else $error("stray error");
   a_refused_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("data");
   a_reset_clears: assert property ($fell(reset) |-> phys_out == 4'h0 && !fso_state)
      else $error("output not cleared");
   a_all_low_off: assert property (safety_in == 8'h00 |=> !fso_state)
      else $error("state on with inputs low");
   a_state_on_pin: assert property (fso_state |-> phys_out != 4'h0) else $error("no pin");
   a_rise_has_cause: assert property ($rose(fso_state) |->
      $past(logic_out) != 4'h0 || $past(safety_in[7])) else $error("rise without cause");
   a_enable_was_low: assert property ($rose(fso_state) && !$past(safety_in[7]) |->
      $past(logic_out, 2) != 4'hf) else $error("enable not low before");
endmodule
bind fsbl_top fsbl_top_asserts chk_u (.ref_clk(ref_clk), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .safety_in(safety_in), .logic_out(logic_out),
   .phys_out(phys_out), .fso_state(fso_state));

// File: verification/fsbl_field_model.sv
// Field model: safety sensors and the normal logic path to the module outputs
`timescale 1ns/1ps
module fsbl_field_model (
   input wire logic ref_clk,
   input wire logic [7:0] sens_set,
   input wire logic [3:0] drv_set,
   output logic [7:0] safety_in,
   output logic [3:0] logic_out
);
   // ----------------------------------------
   // Scanned image, one update per logic cycle
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      safety_in <= sens_set;
      // Normal path drops outputs only when all sensors are low; otherwise fast shut-off is the only guard
      logic_out <= (sens_set == 8'h00) ? 4'h0 : drv_set;
   end
endmodule

// File: verification/tb_fast_shutoff_bypass_logic.sv
// Testbench: registers, zones, enable order and bypass of the shut-off element
`timescale 1ns/1ps
module tb_fast_shutoff_bypass_logic;
   import fsbl_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, sens_set = 8'h00, safety_in;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, fso_state;
   logic [3:0] drv_set = 4'h0, logic_out, phys_out;
   int fail_count = 0, n_compared = 0, cyc = 0;
   fsbl_top dut_u (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .safety_in(safety_in), .logic_out(logic_out),
      .phys_out(phys_out), .fso_state(fso_state));
   fsbl_field_model field_u (.ref_clk(ref_clk), .sens_set(sens_set), .drv_set(drv_set),
      .safety_in(safety_in), .logic_out(logic_out));
   // ----------------------------------------
   // Clock, hang guard, shared tasks
   // ----------------------------------------
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
         input logic [31:0] x, input logic e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      if (!w) chk("rdata", prdata, x);
      chk("pslverr", {31'h0, pslverr}, {31'h0, e});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic field(input logic [7:0] s, input logic [3:0] d);
      @(posedge ref_clk);
      sens_set <= s;
      drv_set <= d;
      repeat (5) @(posedge ref_clk);
   endtask
   task automatic out_is(input logic [4:0] x);
      chk("state_pins", {27'h0, fso_state, phys_out}, {27'h0, x});
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_registers();
      acc(1'b0, CTRL_ADDR, 32'h0, 32'h0000_0800, 1'b0);
      acc(1'b0, ZONE_ADDR, 32'h0, 32'h0000_5555, 1'b0);
      acc(1'b0, 8'h0c, 32'h0, 32'h0, 1'b1);
      acc(1'b1, STATUS_ADDR, 32'hffff_ffff, 32'h0, 1'b1);
      out_is(5'h00);
      $display("test registers done");
   endtask
   task automatic test_zones();
      acc(1'b1, ZONE_ADDR, 32'h0000_0039, 32'h0, 1'b0);
      acc(1'b1, CTRL_ADDR, 32'h0002_0300, 32'h0, 1'b0);
      field(8'h05, 4'h0);
      field(8'h05, 4'h4);
      out_is(5'h14);
      field(8'h04, 4'h4);
      out_is(5'h00);
      field(8'h0e, 4'h4);
      out_is(5'h00);
      field(8'h0e, 4'h0);
      field(8'h0e, 4'h4);
      out_is(5'h14);
      acc(1'b0, STATUS_ADDR, 32'h0, 32'h0000_460e, 1'b0);
      field(8'h00, 4'h0);
      field(8'h05, 4'h4);
      out_is(5'h00);
      field(8'h00, 4'h0);
      $display("test zones done");
   endtask
   task automatic test_bypass();
      acc(1'b1, CTRL_ADDR, 32'h0001_0801, 32'h0, 1'b0);
      // Count of eight must come back clamped to seven in the bypass variant
      acc(1'b0, CTRL_ADDR, 32'h0, 32'h0001_0701, 1'b0);
      @(posedge ref_clk);
      sens_set <= 8'h80;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      out_is(5'h00);
      // First cycle after three high cycles: the bypass must hold the output now
      repeat (1) @(posedge ref_clk);
      @(negedge ref_clk);
      out_is(5'h12);
      field(8'h00, 4'h0);
      out_is(5'h00);
      $display("test bypass done");
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      test_registers();
      test_zones();
      test_bypass();
      give_verdict();
   end
endmodule
